// [hw/pmm_pkg.sv]
// Purpose: Shared constants and types for the paged memory mapper
// Assumes: One bus clock, synchronous active-high reset
// Notes:   Register offsets are byte offsets on the plain register port

package pmm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int REG_AW  = 4;           // Register port address width
  localparam int DATA_W  = 8;           // Data byte width
  localparam int PTR_W   = 17;          // Implemented linear pointer width
  localparam int PAGE_W  = 3;           // Implemented page select width
  localparam int CPU_AW  = 16;          // Core address width
  localparam int WIN_LSB = 14;          // Address bits kept inside the window

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [REG_AW-1:0] OFF_PAGE  = 4'h0;  // Program page select
  localparam logic [REG_AW-1:0] OFF_PTR2  = 4'h1;  // Pointer bits 16
  localparam logic [REG_AW-1:0] OFF_PTR1  = 4'h2;  // Pointer bits 15:8
  localparam logic [REG_AW-1:0] OFF_PTR0  = 4'h3;  // Pointer bits 7:0
  localparam logic [REG_AW-1:0] OFF_WORD  = 4'h4;  // Word post-increment port
  localparam logic [REG_AW-1:0] OFF_BYTE  = 4'h5;  // Byte post-increment port
  localparam logic [REG_AW-1:0] OFF_PLAIN = 4'h6;  // Plain linear data port
  localparam logic [REG_AW-1:0] OFF_ADD   = 4'h7;  // Pointer add register

  // ----------------------------------------------------------------
  // Reset values and decode
  // ----------------------------------------------------------------
  localparam logic [PAGE_W-1:0] PAGE_RST  = 3'h2;
  localparam logic [PTR_W-1:0]  PTR_RST   = 17'h0_0000;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0]        WIN_TAG   = 2'h2;  // A15:A14 of the window
  localparam int                LANES     = 3;     // Pointer byte lanes

  // ----------------------------------------------------------------
  // Paged call / return sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [9:0]
  {
    ST_IDLE  = 10'h001,
    ST_C_RAL = 10'h002,
    ST_C_RAH = 10'h004,
    ST_C_PG  = 10'h008,
    ST_C_LD  = 10'h010,
    ST_C_JMP = 10'h020,
    ST_R_PG  = 10'h040,
    ST_R_AH  = 10'h080,
    ST_R_AL  = 10'h100,
    ST_R_JMP = 10'h200
  } pmm_seq_t;

endpackage

// [hw/pmm_ptr_alu.sv]
// Purpose: Next-value logic for the linear address pointer
// Assumes: At most one of load, add and increment per cycle
// Notes:   All arithmetic wraps at the pointer width

`timescale 1ns/1ns

module pmm_ptr_alu
#(
  parameter int PTR_W = 17
)
(
  input  wire logic [PTR_W-1:0] ptr_cur,   // Current pointer
  input  wire logic             inc_en,    // Post-increment request
  input  wire logic             add_en,    // Signed add request
  input  wire logic [7:0]       add_val,   // Two's complement addend
  input  wire logic [2:0]       ld_en,     // Byte lane load enables
  input  wire logic [7:0]       ld_byte,   // Byte to load
  output logic      [PTR_W-1:0] ptr_nxt    // Next pointer
);

  logic [PTR_W-1:0] add_ext;

  // ----------------------------------------------------------------
  // Sign extension of the addend
  // ----------------------------------------------------------------
  assign add_ext = {{(PTR_W-8){add_val[7]}}, add_val};

  // Load first, then add, then increment; wrap, no overflow flag
  always_comb
  begin
    ptr_nxt = ptr_cur;
    if (|ld_en)
    begin
      for (int b = 0; b < PTR_W; b++)
      begin
        if (ld_en[b/8])
        begin
          ptr_nxt[b] = ld_byte[b%8];
        end
      end
    end
    else if (add_en)
    begin
      ptr_nxt = ptr_cur + add_ext;
    end
    else if (inc_en)
    begin
      ptr_nxt = ptr_cur + {{(PTR_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// [hw/pmm_top.sv]
// Purpose: Paged memory mapper: page window, paged call/return, linear pointer
// Assumes: Core owns the stack; stack read data valid while pull is high
// Notes:   Extended memory reads are combinational on the pointer address
//
// Overview of operation
// - Plain data port reads or writes the pointed byte, pointer unchanged.
// - Byte and word post-increment ports access like plain, then pointer plus one.
// - Word port sits one address below the byte port for 16-bit loads.
// - Add register write adds the signed byte to the pointer.
// - Writing 0x7f advances pointer 127; writing 0x80 moves back 128.
// - Pointer reaches any location, independent of the selected page.
// - Page select chooses which 16K block appears in the window.
// - Window accesses combine page select with core address for decode.
// - Paged call: stack return address, push page, load page, jump.
// - Paged call takes new page and window target from its operands.
// - Paged call completes atomically with interrupts held off.
// - Paged return: pull page, pull 16-bit return address, resume.
// - Paged return completes atomically with interrupts held off.
// - Pointer may be 22 bits architecturally; this one is narrower.
// - After reset page select holds page 2.
// - Window address is page select above core address bits 13 to 0.
// - Pointer is 17 bits over three registers, addressing all data ports.

`timescale 1ns/1ns

module pmm_top
#(
  parameter int PTR_W  = pmm_pkg::PTR_W,
  parameter int PAGE_W = pmm_pkg::PAGE_W
)
(
  input  wire logic                        clk_sys,      // Bus clock, 10 MHz
  input  wire logic                        rst,          // Sync reset, high
  input  wire logic [pmm_pkg::REG_AW-1:0]  reg_addr,     // Register offset
  input  wire logic [pmm_pkg::DATA_W-1:0]  reg_wdata,    // Register write data
  input  wire logic                        reg_wr,       // Write strobe
  input  wire logic                        reg_rd,       // Read strobe
  output logic      [pmm_pkg::DATA_W-1:0]  reg_rdata_r,  // Read data, next cycle
  output logic      [PTR_W-1:0]            mem_raddr_r,  // Linear read address
  input  wire logic [pmm_pkg::DATA_W-1:0]  mem_rdata,    // Linear read data
  output logic                             mem_wr_r,     // Linear write pulse
  output logic      [PTR_W-1:0]            mem_waddr_r,  // Linear write address
  output logic      [pmm_pkg::DATA_W-1:0]  mem_wdata_r,  // Linear write data
  input  wire logic [pmm_pkg::CPU_AW-1:0]  cpu_addr,     // Core address
  output logic      [PAGE_W+13:0]          ext_addr_r,   // Extended address
  output logic                             ext_win_r,    // Window hit
  input  wire logic                        call_start,   // Paged call pulse
  input  wire logic [7:0]                  call_page,    // Immediate page
  input  wire logic [pmm_pkg::CPU_AW-1:0]  call_target,  // Target address
  input  wire logic [pmm_pkg::CPU_AW-1:0]  call_ret,     // Return address
  input  wire logic                        ret_start,    // Paged return pulse
  output logic                             stk_push_r,   // Stack push pulse
  output logic      [7:0]                  stk_wdata_r,  // Byte to push
  output logic                             stk_pull_r,   // Stack pull pulse
  input  wire logic [7:0]                  stk_rdata,    // Pulled byte
  output logic                             jump_r,       // Load PC pulse
  output logic      [pmm_pkg::CPU_AW-1:0]  jump_addr_r,  // New PC
  output logic                             irq_block_r,  // Interrupts held off
  output logic      [PAGE_W-1:0]           page_r        // Program page select
);

  import pmm_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic             acc_any;
  logic             sel_page;
  logic             sel_ptr2;
  logic             sel_ptr1;
  logic             sel_ptr0;
  logic             sel_word;
  logic             sel_byte;
  logic             sel_plain;
  logic             sel_add;
  logic             data_port;
  logic             post_inc;
  logic [2:0]       ptr_ld;
  logic [PTR_W-1:0] ptr_r;
  logic [PTR_W-1:0] ptr_nxt;
  pmm_seq_t         st_r;
  logic [PAGE_W-1:0] call_page_r;
  logic [CPU_AW-1:0] target_r;
  logic [CPU_AW-1:0] ret_addr_r;

  // Port selects from the offset
  assign acc_any   = reg_wr | reg_rd;
  assign sel_page  = (reg_addr == OFF_PAGE);
  assign sel_ptr2  = (reg_addr == OFF_PTR2);
  assign sel_ptr1  = (reg_addr == OFF_PTR1);
  assign sel_ptr0  = (reg_addr == OFF_PTR0);
  assign sel_word  = (reg_addr == OFF_WORD);
  assign sel_byte  = (reg_addr == OFF_BYTE);
  assign sel_plain = (reg_addr == OFF_PLAIN);
  assign sel_add   = (reg_addr == OFF_ADD);

  // All three data ports use the same pointer as address
  assign data_port = sel_word | sel_byte | sel_plain;
  assign post_inc  = acc_any & (sel_word | sel_byte);
  assign ptr_ld    = {reg_wr & sel_ptr2, reg_wr & sel_ptr1, reg_wr & sel_ptr0};

  // ----------------------------------------------------------------
  // Linear address pointer
  // ----------------------------------------------------------------
  pmm_ptr_alu
  #(
    .PTR_W   (PTR_W)
  )
  u_ptr_alu
  (
    .ptr_cur (ptr_r),
    .inc_en  (post_inc),
    .add_en  (reg_wr & sel_add),
    .add_val (reg_wdata),
    .ld_en   (ptr_ld),
    .ld_byte (reg_wdata),
    .ptr_nxt (ptr_nxt)
  );

  // Pointer register; page select never enters here
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ptr_r <= PTR_RST;
    end
    else
    begin
      ptr_r <= ptr_nxt;
    end
  end

  // Read address is the live pointer, so a read sees the old value
  assign mem_raddr_r = ptr_r;

  // ----------------------------------------------------------------
  // Linear data writes
  // ----------------------------------------------------------------
  // Address captured before the increment lands, so stores don't skip
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mem_wr_r    <= 1'b0;
      mem_waddr_r <= PTR_RST;
      mem_wdata_r <= BYTE_ZERO;
    end
    else
    begin
      mem_wr_r <= reg_wr & data_port;
      if (reg_wr & data_port)
      begin
        mem_waddr_r <= ptr_r;
        mem_wdata_r <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read data
  // ----------------------------------------------------------------
  // Unmapped offsets and the add register read as zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata_r <= BYTE_ZERO;
    end
    else if (reg_rd)
    begin
      case (1'b1)
        sel_page:  reg_rdata_r <= {{(DATA_W-PAGE_W){1'b0}}, page_r};
        sel_ptr2:  reg_rdata_r <= {{(24-PTR_W){1'b0}}, ptr_r[PTR_W-1:16]};
        sel_ptr1:  reg_rdata_r <= ptr_r[15:8];
        sel_ptr0:  reg_rdata_r <= ptr_r[7:0];
        data_port: reg_rdata_r <= mem_rdata;
        default:   reg_rdata_r <= BYTE_ZERO;
      endcase
    end
    else
    begin
      reg_rdata_r <= BYTE_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Program page select
  // ----------------------------------------------------------------
  // Sequencer loads win over a bus write in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      page_r <= PAGE_RST;
    end
    else if (st_r == ST_C_LD)
    begin
      page_r <= call_page_r;
    end
    else if (st_r == ST_R_PG)
    begin
      page_r <= stk_rdata[PAGE_W-1:0];
    end
    else if (reg_wr & sel_page)
    begin
      page_r <= reg_wdata[PAGE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Paging window translation
  // ----------------------------------------------------------------
  // Outside the window the core address passes through unpaged
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ext_win_r  <= 1'b0;
      ext_addr_r <= '0;
    end
    else if (cpu_addr[15:WIN_LSB] == WIN_TAG)
    begin
      ext_win_r  <= 1'b1;
      ext_addr_r <= {page_r, cpu_addr[WIN_LSB-1:0]};
    end
    else
    begin
      ext_win_r  <= 1'b0;
      ext_addr_r <= {{(PAGE_W-2){1'b0}}, cpu_addr};
    end
  end

  // ----------------------------------------------------------------
  // Paged call / return sequencer
  // ----------------------------------------------------------------
  // Call wins if both starts come together; starts ignored while busy.
  // Software writing the page from paged code is not guarded here.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_r        <= ST_IDLE;
      stk_push_r  <= 1'b0;
      stk_wdata_r <= BYTE_ZERO;
      stk_pull_r  <= 1'b0;
      jump_r      <= 1'b0;
      jump_addr_r <= '0;
      irq_block_r <= 1'b0;
      call_page_r <= PAGE_RST;
      target_r    <= '0;
      ret_addr_r  <= '0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          jump_r <= 1'b0;
          if (call_start)
          begin
            st_r        <= ST_C_RAL;
            irq_block_r <= 1'b1;
            stk_push_r  <= 1'b1;
            stk_wdata_r <= call_ret[7:0];
            call_page_r <= call_page[PAGE_W-1:0];
            target_r    <= call_target;
          end
          else if (ret_start)
          begin
            st_r        <= ST_R_PG;
            irq_block_r <= 1'b1;
            stk_pull_r  <= 1'b1;
          end
          if (call_start)
          begin
            ret_addr_r <= call_ret;
          end
        end
        ST_C_RAL:
        begin
          st_r        <= ST_C_RAH;
          stk_wdata_r <= ret_addr_r[15:8];
        end
        ST_C_RAH:
        begin
          st_r        <= ST_C_PG;
          stk_wdata_r <= {{(8-PAGE_W){1'b0}}, page_r};
        end
        ST_C_PG:
        begin
          st_r       <= ST_C_LD;
          stk_push_r <= 1'b0;
        end
        ST_C_LD:
        begin
          st_r        <= ST_C_JMP;
          jump_r      <= 1'b1;
          jump_addr_r <= target_r;
        end
        ST_R_PG:
        begin
          st_r <= ST_R_AH;
        end
        ST_R_AH:
        begin
          st_r                <= ST_R_AL;
          ret_addr_r[15:8]    <= stk_rdata;
        end
        ST_R_AL:
        begin
          st_r        <= ST_R_JMP;
          stk_pull_r  <= 1'b0;
          jump_r      <= 1'b1;
          jump_addr_r <= {ret_addr_r[15:8], stk_rdata};
        end
        ST_C_JMP, ST_R_JMP:
        begin
          st_r        <= ST_IDLE;
          jump_r      <= 1'b0;
          irq_block_r <= 1'b0;
        end
        default:
        begin
          st_r        <= ST_IDLE;
          stk_push_r  <= 1'b0;
          stk_pull_r  <= 1'b0;
          jump_r      <= 1'b0;
          irq_block_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_plain_keeps_ptr;
    @(posedge clk_sys) disable iff (rst)
    (acc_any && sel_plain) |=> (ptr_r == $past(ptr_r));
  endproperty
  a_plain_keeps_ptr: assert property (p_plain_keeps_ptr)
    else $error("plain port access moved the pointer");

  property p_plain_read_data;
    @(posedge clk_sys) disable iff (rst)
    (reg_rd && sel_plain) |=> (reg_rdata_r == $past(mem_rdata));
  endproperty
  a_plain_read_data: assert property (p_plain_read_data)
    else $error("plain port read returned wrong byte");

  property p_post_inc;
    @(posedge clk_sys) disable iff (rst)
    (acc_any && (sel_word || sel_byte))
      |=> (ptr_r == PTR_W'($past(ptr_r) + 1'b1));
  endproperty
  a_post_inc: assert property (p_post_inc)
    else $error("post-increment port did not step the pointer");

  property p_write_old_addr;
    @(posedge clk_sys) disable iff (rst)
    (reg_wr && data_port) |=> (mem_wr_r && mem_waddr_r == $past(ptr_r));
  endproperty
  a_write_old_addr: assert property (p_write_old_addr)
    else $error("data store used the updated pointer");

  property p_signed_add;
    @(posedge clk_sys) disable iff (rst)
    (reg_wr && sel_add)
      |=> (ptr_r == PTR_W'($past(ptr_r) + {{(PTR_W-8){$past(reg_wdata[7])}},
                                           $past(reg_wdata)}));
  endproperty
  a_signed_add: assert property (p_signed_add)
    else $error("pointer add gave wrong sum");

  property p_add_reads_zero;
    @(posedge clk_sys) disable iff (rst)
    (reg_rd && sel_add) |=> (reg_rdata_r == BYTE_ZERO);
  endproperty
  a_add_reads_zero: assert property (p_add_reads_zero)
    else $error("add register read not zero");

  property p_page_reset;
    @(posedge clk_sys) disable iff (rst)
    $past(rst) |-> (page_r == PAGE_RST);
  endproperty
  a_page_reset: assert property (p_page_reset)
    else $error("page select not 2 after reset");

  property p_window_addr;
    @(posedge clk_sys) disable iff (rst)
    (cpu_addr[15:WIN_LSB] == WIN_TAG)
      |=> (ext_win_r && ext_addr_r == {$past(page_r), $past(cpu_addr[13:0])});
  endproperty
  a_window_addr: assert property (p_window_addr)
    else $error("window address formed wrongly");

  property p_call_order;
    @(posedge clk_sys) disable iff (rst)
    (st_r == ST_IDLE && call_start)
      |=> stk_push_r [*3] ##1 !stk_push_r
          ##1 (jump_r && page_r == $past(call_page[PAGE_W-1:0], 5));
  endproperty
  a_call_order: assert property (p_call_order)
    else $error("paged call steps out of order");

  property p_call_atomic;
    @(posedge clk_sys) disable iff (rst)
    (st_r == ST_IDLE && call_start) |=> irq_block_r [*5] ##1 !irq_block_r;
  endproperty
  a_call_atomic: assert property (p_call_atomic)
    else $error("paged call not held atomic");

  property p_ret_order;
    @(posedge clk_sys) disable iff (rst)
    (st_r == ST_IDLE && !call_start && ret_start)
      |=> ##1 (page_r == $past(stk_rdata[PAGE_W-1:0]))
          ##2 (jump_r && irq_block_r);
  endproperty
  a_ret_order: assert property (p_ret_order)
    else $error("paged return steps out of order");

  property p_ret_atomic;
    @(posedge clk_sys) disable iff (rst)
    (st_r == ST_IDLE && !call_start && ret_start)
      |=> (irq_block_r && stk_pull_r) [*3] ##1 irq_block_r ##1 !irq_block_r;
  endproperty
  a_ret_atomic: assert property (p_ret_atomic)
    else $error("paged return not held atomic");

endmodule

// [test/pmm_core_model.sv]
// Purpose: Core side stand-in: linear memory and call/return stack
// Assumes: Memory and stack answer in the same cycle as asked
// Notes:   Empty stack pulls give a pattern that flips every cycle

`timescale 1ns/1ns

module pmm_core_model
(
  input  wire logic        clk_sys,     // Bus clock
  input  wire logic [16:0] mem_raddr_r, // Read address
  output logic      [7:0]  mem_rdata,   // Read byte
  input  wire logic        mem_wr_r,    // Store pulse
  input  wire logic [16:0] mem_waddr_r, // Store address
  input  wire logic [7:0]  mem_wdata_r, // Store byte
  input  wire logic        stk_push_r,  // Push pulse
  input  wire logic [7:0]  stk_wdata_r, // Pushed byte
  input  wire logic        stk_pull_r,  // Pull pulse
  output logic      [7:0]  stk_rdata    // Pulled byte
);
  logic [7:0] mem [0:131071];
  logic [7:0] stk [0:15];
  logic [3:0] sp     = 4'h0;
  logic [7:0] junk_r = 8'h5A;

  // ----------------------------------------------------------------
  // Memory and stack
  // ----------------------------------------------------------------
  // Untouched bytes hold a fold of their own address
  initial
    for (int a = 0; a < 131072; a++)
      mem[a] = 8'(a) ^ 8'(a >> 9);
  assign mem_rdata = mem[mem_raddr_r];
  // Junk on an empty pull, so a stray pull never looks right
  assign stk_rdata = (stk_pull_r && sp != 4'h0) ? stk[sp - 4'h1] : junk_r;
  always @(posedge clk_sys)
  begin
    junk_r <= ~junk_r;
    if (mem_wr_r)
      mem[mem_waddr_r] <= mem_wdata_r;
    if (stk_push_r)
    begin
      stk[sp] <= stk_wdata_r;
      sp      <= sp + 4'h1;
    end
    else if (stk_pull_r && sp != 4'h0)
      sp <= sp - 4'h1;
  end
endmodule

// [test/tb.sv]
// Purpose: Self-checking bench for the paged memory mapper
// Assumes: Core model answers memory and stack accesses
// Notes:   Random pointers, pages and call operands, seeded once

`timescale 1ns/1ns

module tb;
  import pmm_pkg::*;
  logic        clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic        call_start = 0, ret_start = 0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, call_page = 8'h00, d, v, stk_rdata, mem_rdata;
  logic [15:0] cpu_addr = 16'h0000, call_target = 16'h0000, call_ret = 16'h0000, a, t, r;
  logic [16:0] p, mem_raddr_r, mem_waddr_r, ext_addr_r;
  logic [7:0]  reg_rdata_r, mem_wdata_r, stk_wdata_r;
  logic [15:0] jump_addr_r;
  logic [2:0]  page_r, pg, np;
  logic        mem_wr_r, ext_win_r, stk_push_r, stk_pull_r, jump_r, irq_block_r;
  int          num_errors = 0, checks_done = 0;

  pmm_top dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .mem_raddr_r(mem_raddr_r),
    .mem_rdata(mem_rdata), .mem_wr_r(mem_wr_r), .mem_waddr_r(mem_waddr_r),
    .mem_wdata_r(mem_wdata_r), .cpu_addr(cpu_addr), .ext_addr_r(ext_addr_r),
    .ext_win_r(ext_win_r), .call_start(call_start), .call_page(call_page),
    .call_target(call_target), .call_ret(call_ret), .ret_start(ret_start),
    .stk_push_r(stk_push_r), .stk_wdata_r(stk_wdata_r), .stk_pull_r(stk_pull_r),
    .stk_rdata(stk_rdata), .jump_r(jump_r), .jump_addr_r(jump_addr_r),
    .irq_block_r(irq_block_r), .page_r(page_r));
  pmm_core_model core_u (.clk_sys(clk_sys), .mem_raddr_r(mem_raddr_r), .mem_rdata(mem_rdata),
    .mem_wr_r(mem_wr_r), .mem_waddr_r(mem_waddr_r), .mem_wdata_r(mem_wdata_r),
    .stk_push_r(stk_push_r), .stk_wdata_r(stk_wdata_r), .stk_pull_r(stk_pull_r),
    .stk_rdata(stk_rdata));

  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  initial
    forever #50 clk_sys = ~clk_sys;
  // Expected memory: stores seen so far, else the address fold
  logic [7:0] tmem [int];
  function automatic logic [7:0] emem(input logic [16:0] x);
    return tmem.exists(x) ? tmem[x] : x[7:0] ^ x[16:9];
  endfunction
  task automatic give_verdict;
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] wd);
    @(posedge clk_sys);
    reg_addr  <= ad;
    reg_wdata <= wd;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    #1;                 // Callers look only after the write has landed
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] ad, output logic [7:0] rv);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata_r;
  endtask
  task automatic setp(input logic [16:0] x);
    wr(OFF_PTR2, {7'h00, x[16]});
    wr(OFF_PTR1, x[15:8]);
    wr(OFF_PTR0, x[7:0]);
  endtask
  // Bounded wait for the jump pulse
  task automatic wait_jump;
    int n;
    n = 0;
    while (jump_r !== 1'b1)
    begin
      if (n == 20)
      begin
        num_errors++;
        give_verdict();
      end
      @(posedge clk_sys);
      #1 n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(97890));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFF_PAGE, d); chk({9'h000, d}, {14'h0000, PAGE_RST});
    rd(OFF_ADD, d); chk({9'h000, d}, 17'h0_0000);
    rd(4'hF, d); chk({9'h000, d}, 17'h0_0000);
    // Data ports; first pass sits on the wrap corner
    for (int i = 0; i < 6; i++)
    begin
      p = (i == 0) ? 17'h1_FFFF : 17'($urandom);
      v = 8'($urandom);
      wr(OFF_PAGE, 8'(i));
      setp(p); chk(mem_raddr_r, p);
      rd(OFF_PTR2, d); chk({9'h000, d}, {16'h0000, p[16]});
      rd(OFF_PTR1, d); chk({9'h000, d}, {9'h000, p[15:8]});
      rd(OFF_PTR0, d); chk({9'h000, d}, {9'h000, p[7:0]});
      rd(OFF_PLAIN, d); chk({9'h000, d}, {9'h000, emem(p)});
      chk(mem_raddr_r, p);
      rd(OFF_WORD, d); chk({9'h000, d}, {9'h000, emem(p)});
      rd(OFF_BYTE, d); chk({9'h000, d}, {9'h000, emem(p + 17'h0_0001)});
      chk(mem_raddr_r, p + 17'h0_0002);
      wr(OFF_BYTE, v); tmem[p + 17'h0_0002] = v;
      wr(OFF_PLAIN, ~v); tmem[p + 17'h0_0003] = ~v;
      chk(mem_raddr_r, p + 17'h0_0003);
      setp(p + 17'h0_0002);
      rd(OFF_WORD, d); chk({9'h000, d}, {9'h000, v});
      rd(OFF_PLAIN, d); chk({9'h000, d}, {9'h000, ~v});
      // Word port store, then step back with a negative add
      wr(OFF_WORD, v ^ 8'h3C); tmem[p + 17'h0_0003] = v ^ 8'h3C;
      wr(OFF_ADD, 8'hFF); chk(mem_raddr_r, p + 17'h0_0003);
      rd(OFF_PLAIN, d); chk({9'h000, d}, {9'h000, v ^ 8'h3C});
    end
    // Signed adds: 0x7f from zero, then 0x80 from there, then random
    setp(17'h0_0000);
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($urandom);
      p = mem_raddr_r;
      wr(OFF_ADD, v); chk(mem_raddr_r, p + {{9{v[7]}}, v});
    end
    // Window: every page, both edges, one miss just above
    for (int i = 0; i < 9; i++)
    begin
      wr(OFF_PAGE, 8'(i));
      a = (i == 0) ? 16'h8000 : (i == 7) ? 16'hBFFF : (i == 8) ? 16'hC000 :
          (16'h8000 | (16'($urandom) & 16'h3FFF));
      @(posedge clk_sys);
      cpu_addr <= a;
      @(posedge clk_sys);
      #1 chk(ext_addr_r, (i == 8) ? {1'b0, a} : {3'(i), a[13:0]});
      chk({16'h0000, ext_win_r}, (i == 8) ? 17'h0_0000 : 17'h0_0001);
    end
    // Second reset in mid-run; page was left at 0, so page 2 is visible
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFF_PAGE, d); chk({9'h000, d}, {14'h0000, PAGE_RST});
    chk(mem_raddr_r, PTR_RST);
    // Paged call with a refused return inside it, then the return
    for (int i = 0; i < 3; i++)
    begin
      pg = page_r;
      np = 3'($urandom);
      t  = 16'h8000 | (16'($urandom) & 16'h3FFF);
      r  = 16'($urandom);
      @(posedge clk_sys);
      call_start  <= 1'b1;
      ret_start   <= (i == 0);     // First pass: call must beat a return
      call_page   <= {5'($urandom), np};
      call_target <= t;
      call_ret    <= r;
      @(posedge clk_sys);
      call_start  <= 1'b0;
      ret_start   <= 1'b1;
      @(posedge clk_sys);
      ret_start   <= 1'b0;
      #1 chk({16'h0000, irq_block_r}, 17'h0_0001);
      wait_jump();
      chk({1'b0, jump_addr_r}, {1'b0, t});
      chk({14'h0000, page_r}, {14'h0000, np});
      repeat (2) @(posedge clk_sys);
      ret_start <= 1'b1;
      @(posedge clk_sys);
      ret_start <= 1'b0;
      #1 chk({16'h0000, irq_block_r}, 17'h0_0001);
      wait_jump();
      chk({1'b0, jump_addr_r}, {1'b0, r});
      chk({14'h0000, page_r}, {14'h0000, pg});
    end
    give_verdict();
  end
endmodule
